// file: test/nar_prom_model.sv
/*
  Behavioural address memory with its feedback shift stages.
  Assumes the bench supplies the address to hold and the ring wire fault.
*/
module nar_prom_model (
  input wire logic ring_insert_n_in,
  input wire logic clear_n_in,
  input wire logic shift_clk_in,
  input wire logic ring_wf_in,
  input wire logic absent_in,
  input wire logic [47:0] bia_in,
  output logic wire_fault_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] stage;
  logic [8:0] addr;
  logic col_addr;
  logic pin_now;

  always @(posedge shift_clk_in or negedge clear_n_in) begin
    if (!clear_n_in) stage <= 7'h00;
    else stage <= stage + 7'h01;
  end
  assign addr = {ring_insert_n_in, ring_wf_in, stage};
  assign col_addr = (addr[6:0] < 7'h30) ? ~bia_in[7'd47 - addr[6:0]] : 1'b0;
  // inserted passes fault; an absent memory leaves the pull-up
  assign pin_now = !addr[8] ? ring_wf_in : (absent_in ? 1'b1 : col_addr);
  // old word shows until the access time has run
  assign #150 wire_fault_n_out = pin_now;
endmodule : nar_prom_model

// file: test/nar_readout_properties.sv
/*
  Port checker for the node address readout, bound onto nar_readout.
  Assumes one clock domain and a synchronous active-low reset.
*/
module nar_readout_properties (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic init_start_in,
  input wire logic insert_req_in,
  input wire logic join_req_in,
  input wire logic ring_insert_n_out,
  input wire logic prom_clear_n_out,
  input wire logic prom_shift_clk_out,
  input wire logic read_busy_out,
  input wire logic prom_present_out,
  input wire logic address_valid_out,
  input wire logic [nar_pkg::ADDR_W-1:0] burned_in_address_out,
  input wire logic join_done_out,
  input wire logic join_error_out
);
  // ==========================================================
  // walk length and shift pulse counters
  logic [10:0] cyc;
  logic [7:0] shifts;
  logic sh_q;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  // counters restart whenever the walk is not running
  always_ff @(posedge clk_sys_in) begin
    sh_q <= prom_shift_clk_out;
    cyc <= (!rst_b_in || !read_busy_out) ? 11'h000 : cyc + 11'h001;
    if (!rst_b_in || !read_busy_out) shifts <= 8'h00;
    else if (prom_shift_clk_out && !sh_q) shifts <= shifts + 8'h01;
  end

  // ==========================================================
  // assertions
  walk_insert_off_a: assert property (read_busy_out |-> ring_insert_n_out)
    else $error("ring insert low during walk");
  no_insert_req_a: assert property (!insert_req_in |=> ring_insert_n_out)
    else $error("ring insert low without request");
  shift_in_walk_a: assert property (prom_shift_clk_out |-> read_busy_out)
    else $error("shift clock outside walk");
  walk_shifts_a: assert property ($fell(read_busy_out) |-> shifts == 8'h7F)
    else $error("walk shift count wrong");
  walk_length_a: assert property ($fell(read_busy_out) |-> cyc > 11'h514 && cyc < 11'h6A4)
    else $error("walk length out of range");
  walk_clear_a: assert property ($rose(read_busy_out) |-> !prom_clear_n_out)
    else $error("walk starts without clear");
  join_answer_a: assert property (join_req_in && !read_busy_out && !init_start_in ##1
    !init_start_in |=> join_done_out) else $error("join not answered");
  join_error_a: assert property (join_done_out && join_error_out |-> !address_valid_out)
    else $error("join error with valid address");
  valid_format_a: assert property (address_valid_out |-> prom_present_out &&
    burned_in_address_out[47:46] == 2'h1) else $error("valid flag on bad format");
  busy_clears_a: assert property ($rose(read_busy_out) |-> ##[0:1] !prom_present_out)
    else $error("presence not cleared at walk start");

  // main scenarios
  cover property ($fell(read_busy_out) && address_valid_out);
  cover property (join_done_out && join_error_out);
  cover property (join_done_out && !join_error_out);
endmodule : nar_readout_properties

bind nar_readout nar_readout_properties u_props (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .init_start_in(init_start_in),
  .insert_req_in(insert_req_in), .join_req_in(join_req_in),
  .ring_insert_n_out(ring_insert_n_out), .prom_clear_n_out(prom_clear_n_out),
  .prom_shift_clk_out(prom_shift_clk_out), .read_busy_out(read_busy_out),
  .prom_present_out(prom_present_out), .address_valid_out(address_valid_out),
  .burned_in_address_out(burned_in_address_out), .join_done_out(join_done_out),
  .join_error_out(join_error_out)
);

// file: test/tb_top.sv
/*
  Self-checking bench for the node address readout.
  Assumes the memory model and the bound checker are compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0, init_start_in = 1'b0, insert_req_in = 1'b0, join_req_in = 1'b0;
  logic ring_wf = 1'b1, absent = 1'b0, pin, ring_insert_n, clear_n, shift_clk;
  logic wf_seen, busy, present, valid, done, err;
  logic [47:0] join_addr_in = 48'h0, burned_in_address = 48'h0, bia_out, node;
  int errors = 0, checked = 0, cycles = 0;

  // ==========================================================
  // clock, design and memory
  always #20 clk_sys_in = ~clk_sys_in;
  nar_readout DUT (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1),
    .init_start_in(init_start_in), .insert_req_in(insert_req_in), .join_req_in(join_req_in),
    .join_addr_in(join_addr_in), .wire_fault_n_in(pin), .ring_insert_n_out(ring_insert_n),
    .prom_clear_n_out(clear_n), .prom_shift_clk_out(shift_clk), .wire_fault_seen_out(wf_seen),
    .read_busy_out(busy), .prom_present_out(present), .address_valid_out(valid),
    .burned_in_address_out(bia_out), .join_done_out(done), .join_error_out(err),
    .node_address_out(node)
  );
  nar_prom_model u_prom (
    .ring_insert_n_in(ring_insert_n), .clear_n_in(clear_n), .shift_clk_in(shift_clk),
    .ring_wf_in(ring_wf), .absent_in(absent), .bia_in(burned_in_address), .wire_fault_n_out(pin)
  );

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // a second start inside the walk must be ignored
  task automatic walk(input logic [47:0] a, input logic gone, input logic exp_p, exp_v);
    int n;
    burned_in_address = a;
    absent = gone;
    init_start_in = 1'b1;
    @(negedge clk_sys_in) init_start_in = 1'b0;
    @(negedge clk_sys_in) init_start_in = 1'b1;
    @(negedge clk_sys_in) init_start_in = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk_sys_in);
      n++;
    end
    check("walk busy", 48'h0, {47'h0, busy});
    check("present", {47'h0, exp_p}, {47'h0, present});
    check("valid", {47'h0, exp_v}, {47'h0, valid});
    check("address", gone ? 48'h0 : a, bia_out);
  endtask : walk

  // answer comes two cycles after an idle request
  task automatic join_chk(input logic [47:0] a, input logic exp_e, input logic [47:0] exp_n);
    join_addr_in = a;
    join_req_in = 1'b1;
    @(negedge clk_sys_in) join_req_in = 1'b0;
    // done stands for one cycle only, so look in the cycle after the latch
    @(negedge clk_sys_in);
    check("join done", 48'h1, {47'h0, done});
    check("join error", {47'h0, exp_e}, {47'h0, err});
    check("node address", exp_n, node);
  endtask : join_chk

  // settle covers access time and the input synchroniser
  task automatic insert_chk();
    insert_req_in = 1'b1;
    for (int i = 0; i < 2; i++) begin
      ring_wf = i[0];
      repeat (8) @(negedge clk_sys_in);
      check("inserted", 48'h0, {47'h0, ring_insert_n});
      check("fault seen", {47'h0, i[0]}, {47'h0, wf_seen});
    end
    insert_req_in = 1'b0;
    ring_wf = 1'b1;
  endtask : insert_chk

  // ==========================================================
  // hang guard and main sequence
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 12000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    join_chk(48'h0, 1'b1, 48'h0);
    walk(48'h4A5B_6C7D_8E9F, 1'b0, 1'b1, 1'b1);
    join_chk(48'h0, 1'b0, 48'h4A5B_6C7D_8E9F);
    join_chk(48'h1234_5678_9ABC, 1'b0, 48'h1234_5678_9ABC);
    walk(48'h8123_4567_89AB, 1'b0, 1'b1, 1'b0);
    join_chk(48'h0, 1'b1, 48'h0);
    walk(48'h0, 1'b1, 1'b0, 1'b0);
    insert_chk();
    finish_test();
  end
endmodule : tb_top

// file: verilog/nar_pkg.sv
/*
  Shared constants and types for the node address readout: address width,
  walk length, field positions of the format check and the timing counts.
  Assumes a 25 MHz system clock; all counts are derived from it here.
*/
package nar_pkg;

  // ==========================================================
  // address format
  localparam int ADDR_W = 48;
  localparam int BYTE0_BIT0_POS = 47;   // byte 0 sent first, its bit 0 is the msb
  localparam int BYTE0_BIT1_POS = 46;
  localparam logic [1:0] BYTE0_LOW_PATTERN = 2'h1;
  localparam logic [ADDR_W-1:0] ZERO_ADDR = 48'h0;

  // ==========================================================
  // walk of the address memory
  localparam int SHIFT_STAGES = 7;
  localparam int STEPS = 128;
  localparam logic [SHIFT_STAGES-1:0] LAST_STEP = 7'h7F;
  localparam logic [SHIFT_STAGES-1:0] FIRST_STEP = 7'h00;
  // steps marked 1 carry the validation constant, the rest carry address bits
  localparam logic [STEPS-1:0] CONST_STEP_MASK_DEF =
    128'hFFFF_FFFF_FFFF_FFFF_FFFF_0000_0000_0000;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROM_ACCESS_NS = 150;  // longest memory access, settle before sample
  localparam int SHIFT_PULSE_NS = 80;   // least width of shift clock and clear
  localparam int SYNC_STAGES = 2;
  localparam int TIMER_W = 4;
  localparam logic [TIMER_W-1:0] ACCESS_CYC =
    TIMER_W'((PROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
  localparam logic [TIMER_W-1:0] PULSE_CYC =
    TIMER_W'((SHIFT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    NAR_IDLE,
    NAR_CLEAR,
    NAR_SETTLE,
    NAR_SAMPLE,
    NAR_SHIFT,
    NAR_CHECK
  } nar_state_e;

  // format check on a collected address
  function automatic logic nar_format_ok(input logic [ADDR_W-1:0] addr);
    nar_format_ok = ({addr[BYTE0_BIT0_POS], addr[BYTE0_BIT1_POS]} == BYTE0_LOW_PATTERN);
  endfunction : nar_format_ok

endpackage : nar_pkg

// file: verilog/nar_readout.sv
/*
  Node address readout: walks the external address memory through its
  feedback shift register, collects the burned-in address serially on the
  wire-fault input and answers join requests with the node address.
  Assumes the memory, its shift register and the ring interface sit outside;
  the wire-fault pin is asynchronous and is synchronised here.
*/
// Notes on behaviour
// R1: when a join brings no node address, the 48-bit address read from the memory is supplied.
// R2: the address store outside is a one-time memory of 512 words of 4 bits.
// R3: the burned-in address must hold 01 in bits 0 and 1 of byte 0, else the join fails.
// R4: the address bits sit in the memory's second output column.
// R5: the third and fourth output columns are unused and hold all ones.
// R6: the first output column feeds the shift register that forms the seven low address bits.
// R7: while ring insert is driven low the memory sees only its lower 256 locations.
// R8: when inserted, the value seen equals the ring's wire-fault line.
// R9: each initialization fetches the address, used as station address if the join gives zero.
// R10: presence is found from the validation coding only, and a bad address fails the join.
// R11: the address and validation code appear twice in the upper half, once per wire fault.
// R12: the address arrives serially, bit by bit, through the wire-fault input.
// R13: the memory holds the complement of each address bit since the input is inverted.
// R14: memory address bit 8 is ring insert, bit 7 wire fault, bits 6 to 0 the shift stages.
module nar_readout #(
  parameter logic [nar_pkg::STEPS-1:0] CONST_STEP_MASK = nar_pkg::CONST_STEP_MASK_DEF
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic init_start_in,
  input wire logic insert_req_in,
  input wire logic join_req_in,
  input wire logic [nar_pkg::ADDR_W-1:0] join_addr_in,
  input wire logic wire_fault_n_in,
  output logic ring_insert_n_out,
  output logic prom_clear_n_out,
  output logic prom_shift_clk_out,
  output logic wire_fault_seen_out,
  output logic read_busy_out,
  output logic prom_present_out,
  output logic address_valid_out,
  output logic [nar_pkg::ADDR_W-1:0] burned_in_address_out,
  output logic join_done_out,
  output logic join_error_out,
  output logic [nar_pkg::ADDR_W-1:0] node_address_out
);

  // ==========================================================
  // pin synchroniser
  logic wf_meta;
  logic wf_sync;

  // first stage feeds only the second
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      wf_meta <= 1'b1;
      wf_sync <= 1'b1;
    end else if (clk_en_in) begin
      wf_meta <= wire_fault_n_in;
      wf_sync <= wf_meta;
    end
  end

  // ==========================================================
  // sequencer
  nar_pkg::nar_state_e state;
  nar_pkg::nar_state_e next_state;
  logic [nar_pkg::SHIFT_STAGES-1:0] step;
  logic timer_done;
  logic timer_go;
  logic [nar_pkg::TIMER_W-1:0] timer_len;

  wire logic last_step = (step == nar_pkg::LAST_STEP);
  wire logic const_step = CONST_STEP_MASK[step];
  wire logic idle = (state == nar_pkg::NAR_IDLE);
  wire logic read_go = idle && init_start_in;

  // next state of the walk
  always_comb begin
    next_state = state;
    case (state)
      nar_pkg::NAR_IDLE: begin
        // R9 fetch at init
        if (init_start_in) begin
          next_state = nar_pkg::NAR_CLEAR;
        end
      end
      nar_pkg::NAR_CLEAR: begin
        if (timer_done) begin
          next_state = nar_pkg::NAR_SETTLE;
        end
      end
      nar_pkg::NAR_SETTLE: begin
        if (timer_done) begin
          next_state = nar_pkg::NAR_SAMPLE;
        end
      end
      nar_pkg::NAR_SAMPLE: begin
        next_state = last_step ? nar_pkg::NAR_CHECK : nar_pkg::NAR_SHIFT;
      end
      nar_pkg::NAR_SHIFT: begin
        if (timer_done) begin
          next_state = nar_pkg::NAR_SETTLE;
        end
      end
      default: begin
        next_state = nar_pkg::NAR_IDLE;
      end
    endcase
  end

  // timer starts on entry to each timed phase
  assign timer_go = (next_state != state) &&
                    ((next_state == nar_pkg::NAR_CLEAR) ||
                     (next_state == nar_pkg::NAR_SETTLE) ||
                     (next_state == nar_pkg::NAR_SHIFT));
  assign timer_len = (next_state == nar_pkg::NAR_SETTLE) ? nar_pkg::ACCESS_CYC
                                                         : nar_pkg::PULSE_CYC;

  nar_step_timer u_timer (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .start_in(timer_go),
    .len_in(timer_len),
    .done_out(timer_done)
  );

  // state and step index
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      state <= nar_pkg::NAR_IDLE;
      step <= nar_pkg::FIRST_STEP;
    end else if (clk_en_in) begin
      state <= next_state;
      if (read_go) begin
        step <= nar_pkg::FIRST_STEP;
      end else if (state == nar_pkg::NAR_SAMPLE) begin
        step <= step + nar_pkg::SHIFT_STAGES'(1);
      end
    end
  end

  // ==========================================================
  // memory control pins
  wire logic next_busy = (next_state != nar_pkg::NAR_IDLE);

  // clear puts the low address bits at zero; a shift edge steps the walk
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      prom_clear_n_out <= 1'b1;
      prom_shift_clk_out <= 1'b0;
      ring_insert_n_out <= 1'b1;
      read_busy_out <= 1'b0;
      wire_fault_seen_out <= 1'b1;
    end else if (clk_en_in) begin
      prom_clear_n_out <= (next_state != nar_pkg::NAR_CLEAR);
      prom_shift_clk_out <= (next_state == nar_pkg::NAR_SHIFT);
      // R7 low insert keeps the walk away
      ring_insert_n_out <= next_busy || !insert_req_in;
      read_busy_out <= next_busy;
      wire_fault_seen_out <= wf_sync;
    end
  end

  // ==========================================================
  // serial collection
  logic [nar_pkg::ADDR_W-1:0] collect;
  logic const_ok;
  wire logic sampling = (state == nar_pkg::NAR_SAMPLE);

  // pin low reads as a one: the memory holds complements
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      collect <= '0;
      const_ok <= 1'b0;
    end else if (clk_en_in) begin
      if (read_go) begin
        const_ok <= 1'b1;
      end else if (sampling && const_step) begin
        // R10 validation coding
        const_ok <= const_ok && !wf_sync;
      end else if (sampling) begin
        // R12 one bit per step
        collect <= {collect[nar_pkg::ADDR_W-2:0], !wf_sync};
      end
    end
  end

  // result of a walk; an absent memory leaves the pin high and fails here
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      prom_present_out <= 1'b0;
      address_valid_out <= 1'b0;
      burned_in_address_out <= '0;
    end else if (clk_en_in) begin
      if (read_go) begin
        prom_present_out <= 1'b0;
        address_valid_out <= 1'b0;
      end else if (state == nar_pkg::NAR_CHECK) begin
        prom_present_out <= const_ok;
        // R3 byte 0 pattern
        address_valid_out <= const_ok && nar_pkg::nar_format_ok(collect);
        // R1 48-bit address kept
        burned_in_address_out <= collect;
      end
    end
  end

  // ==========================================================
  // join requests
  logic join_pend;
  logic [nar_pkg::ADDR_W-1:0] join_addr;
  wire logic serve = idle && join_pend && !init_start_in;
  wire logic use_stored = (join_addr == nar_pkg::ZERO_ADDR);
  // a new request in the serving cycle keeps the flag set
  wire logic next_join_pend = join_req_in || (join_pend && !serve);

  // request latch; the join waits while a walk runs
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      join_pend <= 1'b0;
      join_addr <= '0;
    end else if (clk_en_in) begin
      join_pend <= next_join_pend;
      if (join_req_in) begin
        join_addr <= join_addr_in;
      end
    end
  end

  // answer: given address, or the stored one when zero was given and it is valid, else zero with error
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      join_done_out <= 1'b0;
      join_error_out <= 1'b0;
      node_address_out <= '0;
    end else if (clk_en_in) begin
      join_done_out <= serve;
      if (serve) begin
        // R9 zero selects stored
        if (use_stored) begin
          // R10 bad address ends join
          join_error_out <= !address_valid_out;
          node_address_out <= address_valid_out ? burned_in_address_out : nar_pkg::ZERO_ADDR;
        end else begin
          join_error_out <= 1'b0;
          node_address_out <= join_addr;
        end
      end
    end
  end

endmodule : nar_readout

// file: verilog/nar_step_timer.sv
/*
  Down-counting phase timer for the readout sequencer.
  Assumes start pulses come from logic on the same clock.
*/
module nar_step_timer (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire logic [nar_pkg::TIMER_W-1:0] len_in,
  output logic done_out
);

  // ==========================================================
  // counter
  logic [nar_pkg::TIMER_W-1:0] count;
  logic running;
  wire logic last = running && (count == nar_pkg::TIMER_W'(1));

  // a restart while running simply reloads
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      count <= '0;
      running <= 1'b0;
      done_out <= 1'b0;
    end else if (clk_en_in) begin
      done_out <= last && !start_in;
      if (start_in) begin
        count <= len_in;
        running <= 1'b1;
      end else if (running) begin
        count <= count - nar_pkg::TIMER_W'(1);
        running <= !last;
      end
    end
  end

endmodule : nar_step_timer
